// [core/ftr_regs.sv]
// Fan tach limit, die and far diode temperature register bank on AHB-Lite
// Contract
// - 360 kHz clock forces period scale one
// - 16-bit tach limit, resets ones, bits 1:0 unused
// - Die temperature read-only 8-bit byte
// - Die high limit writable, resets to 0x46
// - Far upper byte two's complement integer
// - Far lower bits 7:5 fraction, 4:0 zero
// - Signed correction added to converter output
// - Tach lower read freezes upper until read
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module ftr_regs #(
    parameter int ADC_W = 11
) (
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic                         hreadyout,
    output logic                         hresp,
    output logic [31:0]                  hrdata,
    input  wire logic [7:0]              die_temp,
    input  wire ftr_pkg::ftr_far_sample_t far_adc,
    input  wire logic [15:0]             tach_count,
    output ftr_pkg::ftr_tach_cfg_t       tach_cfg,
    output logic [15:0]                  tach_limit,
    output logic [7:0]                   die_high_limit,
    output logic [10:0]                  far_temp
);

    if (ADC_W != 11) begin : g_check
        $error("ftr_regs supports only an 11-bit converter result");
    end

    logic [7:0]  die_high_q;
    logic [7:0]  corr_upper_q;
    logic [2:0]  corr_lower_q;
    logic [7:0]  limit_upper_q;
    logic [5:0]  limit_lower_q;
    logic [1:0]  edge_sel_q;
    logic        clk360_q;
    logic [10:0] far_q;
    logic [2:0]  far_frac_hold_q;
    logic        far_lock_q;
    logic [7:0]  tach_upper_hold_q;
    logic        tach_lock_q;
    logic [31:0] hrdata_q;
    logic        wr_pend_q;
    logic [7:0]  wr_idx_q;
    logic        acc;
    logic [7:0]  idx;
    logic        rd_acc;
    logic [7:0]  rd_d;

    // Zero wait states; the slave never stalls
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    // Only word transfers are expected; hsize is accepted as given
    assign acc    = hsel && hready && (htrans == ftr_pkg::HTRANS_NONSEQ ||
                                       htrans == ftr_pkg::HTRANS_SEQ);
    assign idx    = haddr[9:2];
    assign rd_acc = acc && !hwrite && (haddr[31:10] == 22'h0);

    // Data phase of a write commits on the next edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 8'h00;
        end else begin
            wr_pend_q <= acc && hwrite && (haddr[31:10] == 22'h0);
            wr_idx_q  <= idx;
        end
    end

    // Writable limits and correction
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            die_high_q    <= ftr_pkg::RST_DIE_HIGH;
            corr_upper_q  <= ftr_pkg::RST_CORR;
            corr_lower_q  <= ftr_pkg::RST_CORR[2:0];
            limit_upper_q <= ftr_pkg::RST_LIMIT_UPPER;
            limit_lower_q <= ftr_pkg::RST_LIMIT_LOWER;
            edge_sel_q    <= ftr_pkg::RST_EDGE_SEL;
            clk360_q      <= 1'b0;
        end else if (wr_pend_q) begin
            unique case (wr_idx_q)
                ftr_pkg::IDX_DIE_HIGH:    die_high_q    <= hwdata[7:0];
                ftr_pkg::IDX_CORR_UPPER:  corr_upper_q  <= hwdata[7:0];
                ftr_pkg::IDX_CORR_LOWER:
                    corr_lower_q <= hwdata[ftr_pkg::FRAC_LSB +: 3];
                ftr_pkg::IDX_LIMIT_UPPER: limit_upper_q <= hwdata[7:0];
                ftr_pkg::IDX_LIMIT_LOWER:
                    limit_lower_q <= hwdata[ftr_pkg::LIMIT_LSB +: 6];
                ftr_pkg::IDX_TACH_CTRL: begin
                    edge_sel_q <= hwdata[1:0];
                    clk360_q   <= hwdata[ftr_pkg::CTRL_CLK360];
                end
                default: ;
            endcase
        end
    end

    // Correction added to every conversion; wraps like the converter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            far_q <= 11'h000;
        end else if (far_adc.valid) begin
            far_q <= far_adc.value + {corr_upper_q, corr_lower_q};
        end
    end

    // Upper read latches the matching fraction so a later conversion
    // cannot split the pair
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            far_lock_q      <= 1'b0;
            far_frac_hold_q <= 3'h0;
        end else if (rd_acc && idx == ftr_pkg::IDX_FAR_UPPER) begin
            far_lock_q      <= 1'b1;
            far_frac_hold_q <= far_q[2:0];
        end else if (rd_acc && idx == ftr_pkg::IDX_FAR_LOWER) begin
            far_lock_q <= 1'b0;
        end
    end

    // Lower tach read freezes the upper half until it is read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tach_lock_q       <= 1'b0;
            tach_upper_hold_q <= 8'h00;
        end else if (rd_acc && idx == ftr_pkg::IDX_TACH_LOW_EDGES && !tach_lock_q) begin
            tach_lock_q       <= 1'b1;
            tach_upper_hold_q <= tach_count[15:8];
        end else if (rd_acc && idx == ftr_pkg::IDX_TACH_UPPER) begin
            tach_lock_q <= 1'b0;
        end
    end

    // Read mux; unmapped reads return zero
    always_comb begin
        rd_d = 8'h00;
        unique case (idx)
            ftr_pkg::IDX_DIE_TEMP:    rd_d = die_temp;
            ftr_pkg::IDX_FAR_UPPER:   rd_d = far_q[10:3];
            ftr_pkg::IDX_DIE_HIGH:    rd_d = die_high_q;
            ftr_pkg::IDX_FAR_LOWER:
                rd_d = {(far_lock_q ? far_frac_hold_q : far_q[2:0]), 5'h00};
            ftr_pkg::IDX_CORR_UPPER:  rd_d = corr_upper_q;
            ftr_pkg::IDX_CORR_LOWER:  rd_d = {corr_lower_q, 5'h00};
            ftr_pkg::IDX_TACH_LOW_EDGES: rd_d = {tach_count[7:2], edge_sel_q};
            ftr_pkg::IDX_TACH_UPPER:
                rd_d = tach_lock_q ? tach_upper_hold_q : tach_count[15:8];
            ftr_pkg::IDX_LIMIT_UPPER: rd_d = limit_upper_q;
            ftr_pkg::IDX_LIMIT_LOWER: rd_d = {limit_lower_q, 2'h0};
            ftr_pkg::IDX_TACH_CTRL:   rd_d = {5'h00, clk360_q, edge_sel_q};
            default:                  rd_d = 8'h00;
        endcase
        if (haddr[31:10] != 22'h0) begin
            rd_d = 8'h00;
        end
    end

    // Read data registered at the address phase, stands in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (rd_acc) begin
            hrdata_q <= {24'h00_0000, rd_d};
        end
    end

    // Edge count and period scale
    always_comb begin
        unique case (edge_sel_q)
            ftr_pkg::EDGE_SEL_3: begin
                tach_cfg.edges = ftr_pkg::EDGES_3;
                tach_cfg.scale = ftr_pkg::SCALE_2;
            end
            ftr_pkg::EDGE_SEL_5: begin
                tach_cfg.edges = ftr_pkg::EDGES_5;
                tach_cfg.scale = ftr_pkg::SCALE_1;
            end
            default: begin
                // Reserved code behaves as the two-edge setting
                tach_cfg.edges = ftr_pkg::EDGES_2;
                tach_cfg.scale = ftr_pkg::SCALE_4;
            end
        endcase
        if (clk360_q) begin
            tach_cfg.scale = ftr_pkg::SCALE_1;
        end
    end

    assign tach_limit     = {limit_upper_q, limit_lower_q, 2'h0};
    assign die_high_limit = die_high_q;
    assign far_temp       = far_q;

endmodule : ftr_regs

`default_nettype wire

// [core/ftr_pkg.sv]
// Package for the fan tach and temperature result register bank
package ftr_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_DIE_TEMP       = 8'h00;
    localparam logic [7:0] IDX_FAR_UPPER      = 8'h01;
    localparam logic [7:0] IDX_DIE_HIGH       = 8'h05;
    localparam logic [7:0] IDX_FAR_LOWER      = 8'h10;
    localparam logic [7:0] IDX_CORR_UPPER     = 8'h11;
    localparam logic [7:0] IDX_CORR_LOWER     = 8'h12;
    localparam logic [7:0] IDX_TACH_LOW_EDGES = 8'h46;
    localparam logic [7:0] IDX_TACH_UPPER     = 8'h47;
    localparam logic [7:0] IDX_LIMIT_LOWER    = 8'h48;
    localparam logic [7:0] IDX_LIMIT_UPPER    = 8'h49;
    localparam logic [7:0] IDX_TACH_CTRL      = 8'h4A;

    // Reset values
    localparam logic [7:0] RST_DIE_HIGH    = 8'h46;
    localparam logic [7:0] RST_CORR        = 8'h00;
    localparam logic [7:0] RST_LIMIT_UPPER = 8'hFF;
    localparam logic [5:0] RST_LIMIT_LOWER = 6'h3F;
    localparam logic [1:0] RST_EDGE_SEL    = 2'h1;

    // Field positions
    localparam int FRAC_LSB      = 5;
    localparam int LIMIT_LSB     = 2;
    localparam int CTRL_CLK360   = 2;

    // Edge selection codes
    localparam logic [1:0] EDGE_SEL_2 = 2'h1;
    localparam logic [1:0] EDGE_SEL_3 = 2'h2;
    localparam logic [1:0] EDGE_SEL_5 = 2'h3;

    // Edges used and period scale per code
    localparam logic [2:0] EDGES_2  = 3'h2;
    localparam logic [2:0] EDGES_3  = 3'h3;
    localparam logic [2:0] EDGES_5  = 3'h5;
    localparam logic [2:0] SCALE_4  = 3'h4;
    localparam logic [2:0] SCALE_2  = 3'h2;
    localparam logic [2:0] SCALE_1  = 3'h1;

    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;

    typedef struct packed {
        logic [2:0] edges;
        logic [2:0] scale;
    } ftr_tach_cfg_t;

    typedef struct packed {
        logic [10:0] value;
        logic        valid;
    } ftr_far_sample_t;

endpackage : ftr_pkg

// [testbench/ftr_regs_assertions.sv]
// Assertion checker for the fan tach and temperature register bank
`timescale 1ns/1ps
`default_nettype none
module ftr_regs_chk (
    input wire logic                    hclk,
    input wire logic                    hresetn,
    input wire logic                    hsel,
    input wire logic [31:0]             haddr,
    input wire logic [1:0]              htrans,
    input wire logic                    hwrite,
    input wire logic [31:0]             hwdata,
    input wire logic                    hready,
    input wire logic [31:0]             hrdata,
    input wire ftr_pkg::ftr_far_sample_t far_adc,
    input wire ftr_pkg::ftr_tach_cfg_t   tach_cfg,
    input wire logic [15:0]             tach_limit,
    input wire logic [7:0]              die_high_limit,
    input wire logic [10:0]             far_temp
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Address phase, then the data phase edge that stores
    sequence s_wr_high;
        hsel && hready && htrans == ftr_pkg::HTRANS_NONSEQ && hwrite && haddr == 32'h14 ##1 1'b1;
    endsequence
    // Control write carrying the 360 kHz select in its data phase
    sequence s_wr_clk360;
        hsel && hready && htrans == ftr_pkg::HTRANS_NONSEQ && hwrite && haddr == 32'h128
            ##1 hready && hwdata[2];
    endsequence
    // Address phase of a far lower byte read
    sequence s_rd_far_lower;
        hsel && hready && htrans == ftr_pkg::HTRANS_NONSEQ && !hwrite && haddr == 32'h40;
    endsequence
    a_clk360_scale:
        assert property (s_wr_clk360 |=> tach_cfg.scale == 3'h1) else $error("clk360 scale");
    a_far_low_zero:
        assert property (s_rd_far_lower |=> hrdata[4:0] == 5'h00) else $error("far lower bits");
    a_high_write:
        assert property (s_wr_high |=> die_high_limit == $past(hwdata[7:0])) else $error("high limit");
    a_limit_reset:
        assert property ($rose(hresetn) |-> tach_limit == 16'hFFFC) else $error("limit reset");
    a_limit_low:
        assert property (tach_limit[1:0] == 2'h0) else $error("limit low bits");
    a_edge5_scale:
        assert property (tach_cfg.edges == 3'h5 |-> tach_cfg.scale == 3'h1) else $error("edge5");
    a_edge3_scale:
        assert property (tach_cfg.edges == 3'h3 |-> tach_cfg.scale inside {3'h1, 3'h2}) else $error("edge3");
    a_edge2_scale:
        assert property (tach_cfg.edges == 3'h2 |-> tach_cfg.scale inside {3'h1, 3'h4}) else $error("edge2");
    a_far_hold:
        assert property (!far_adc.valid |=> $stable(far_temp)) else $error("far temp moved");
    a_rdata_upper:
        assert property (hrdata[31:8] == 24'h0) else $error("read data upper");
endmodule : ftr_regs_chk
bind ftr_regs ftr_regs_chk i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .far_adc(far_adc), .tach_cfg(tach_cfg), .tach_limit(tach_limit),
    .die_high_limit(die_high_limit), .far_temp(far_temp));
`default_nettype wire

// [testbench/ftr_regs_test.sv]
// Self-checking bench for the fan tach and temperature register bank
`timescale 1ns/1ps
`default_nettype none
module ftr_regs_test;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  die_temp, die_high_limit;
    logic [15:0] tach_count, tach_limit;
    logic [10:0] far_temp;
    ftr_pkg::ftr_far_sample_t far_adc;
    ftr_pkg::ftr_tach_cfg_t   tach_cfg;
    int          num_errors = 0;
    int          n_tests = 0;
    logic [7:0]  rst_i [6] = '{8'h05, 8'h11, 8'h12, 8'h48, 8'h49, 8'h30};
    logic [7:0]  rst_v [6] = '{8'h46, 8'h00, 8'h00, 8'hFC, 8'hFF, 8'h00};
    // Reserved code 00 first, alone and with the 360 kHz select
    logic [7:0]  codes [7] = '{8'h00, 8'h04, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06};
    logic [5:0]  cfgs [7]  = '{6'h14, 6'h11, 6'h14, 6'h1A, 6'h29, 6'h11, 6'h19};
    ftr_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .die_temp(die_temp),
        .far_adc(far_adc), .tach_count(tach_count), .tach_cfg(tach_cfg),
        .tach_limit(tach_limit), .die_high_limit(die_high_limit), .far_temp(far_temp));
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask : chk
    // Master waits on hready; never assumes zero wait states
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge hclk);
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= w;
        htrans <= ftr_pkg::HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 32'h0);
        chk($sformatf("register %h", idx), {24'h0, e}, rd);
    endtask : rchk
    task automatic pulse(input logic [10:0] v);
        @(posedge hclk);
        far_adc <= {v, 1'b1};
        @(posedge hclk);
        far_adc <= {v, 1'b0};
        @(posedge hclk);
    endtask : pulse
    initial begin
        repeat (3000) @(posedge hclk);
        num_errors++;
        stop_test();
    end
    initial begin
        {hresetn, hwrite, htrans, haddr, hwdata, far_adc} = '0;
        hsel = 1'b1;
        hsize = 3'h2;
        die_temp = 8'hA5;
        tach_count = 16'hABCD;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        chk("limit port", 32'hFFFC, {16'h0, tach_limit});
        chk("high port", 32'h46, {24'h0, die_high_limit});
        foreach (rst_i[k]) rchk(rst_i[k], rst_v[k]);
        $display("reset test done");
        rchk(8'h00, 8'hA5);
        bus(1'b1, 8'h00, 32'h11);
        rchk(8'h00, 8'hA5);
        bus(1'b1, 8'h05, 32'h5A);
        rchk(8'h05, 8'h5A);
        chk("high port", 32'h5A, {24'h0, die_high_limit});
        bus(1'b1, 8'h49, 32'h12);
        bus(1'b1, 8'h48, 32'h37);
        rchk(8'h48, 8'h34);
        chk("limit port", 32'h1234, {16'h0, tach_limit});
        $display("register test done");
        foreach (codes[k]) begin
            bus(1'b1, 8'h4A, {24'h0, codes[k]});
            // Write lands on the edge the task returns at; look once it settles
            @(negedge hclk);
            chk("tach cfg", {26'h0, cfgs[k]}, {26'h0, tach_cfg});
        end
        // Lower read snapshots the count; upper must not follow the live value
        rchk(8'h46, 8'hCE);
        @(posedge hclk);
        tach_count <= 16'h1111;
        rchk(8'h47, 8'hAB);
        rchk(8'h47, 8'h11);
        $display("tach test done");
        bus(1'b1, 8'h11, 32'h01);
        bus(1'b1, 8'h12, 32'h3F);
        rchk(8'h12, 8'h20);
        pulse(11'h7F0);
        chk("far port", 32'h7F9, {21'h0, far_temp});
        rchk(8'h01, 8'hFF);
        pulse(11'h004);
        rchk(8'h10, 8'h20);
        rchk(8'h01, 8'h01);
        rchk(8'h10, 8'hA0);
        $display("far temperature test done");
        // Mid-run reset must bring back the reset values
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        chk("far port", 32'h0, {21'h0, far_temp});
        chk("high port", 32'h46, {24'h0, die_high_limit});
        chk("limit port", 32'hFFFC, {16'h0, tach_limit});
        rchk(8'h11, 8'h00);
        rchk(8'h05, 8'h46);
        $display("second reset test done");
        stop_test();
    end
endmodule : ftr_regs_test
`default_nettype wire
